// file: pae_regs.svh
// Register offsets, field positions, reset values and codes of the primitive assembly block
`ifndef PAE_REGS_SVH
`define PAE_REGS_SVH
`define PAE_OFF_ERR_READ 8'h00
`define PAE_OFF_MODE 8'h04
`define PAE_OFF_STATUS 8'h08
`define PAE_OFF_ATTR_CMD 8'h0C
`define PAE_OFF_ATTR_X 8'h10
`define PAE_OFF_ATTR_Y 8'h14
`define PAE_OFF_ATTR_Z 8'h18
`define PAE_OFF_ATTR_W 8'h1C
`define PAE_OFF_CMD_ERR 8'h20
`define PAE_ERR_NONE 32'h00000000
`define PAE_ERR_BAD_ENUM 32'h00000500
`define PAE_ERR_BAD_VALUE 32'h00000501
`define PAE_ERR_BAD_OP 32'h00000502
`define PAE_ERR_MEM 32'h00000505
`define PAE_FLOAT_ZERO 32'h00000000
`define PAE_FLOAT_ONE 32'h3F800000
`define PAE_MODE_MAX 3'h6
`define PAE_ACMD_SLOT_LSB 0
`define PAE_ACMD_COUNT_LSB 8
`define PAE_ACMD_SIGN_BIT 31
`define PAE_CERR_BAD_OP_BIT 0
`define PAE_CERR_MEM_BIT 1
`endif

// file: pae_pkg.sv
// Types shared by the primitive assembly block
`default_nettype none
package pae_pkg;
    // Primitive modes, in the order of their codes
    typedef enum logic [2:0] {
        PAE_POINTS = 3'h0,
        PAE_LINE_STRIP = 3'h1,
        PAE_LINE_LOOP = 3'h2,
        PAE_LINES = 3'h3,
        PAE_TRI_STRIP = 3'h4,
        PAE_TRI_FAN = 3'h5,
        PAE_TRIS = 3'h6
    } pae_mode_t;
    typedef enum logic [1:0] {
        PAE_PRIM_POINT = 2'h1,
        PAE_PRIM_LINE = 2'h2,
        PAE_PRIM_TRI = 2'h3
    } pae_kind_t;
    // Vertex stream input
    typedef struct packed {
        logic valid;
        logic last;
        logic [31:0] data;
    } pae_vtx_t;
    // Primitive output to the rasterizer
    typedef struct packed {
        logic valid;
        pae_kind_t kind;
        logic [31:0] v0;
        logic [31:0] v1;
        logic [31:0] v2;
    } pae_prim_t;
    // AXI4-Lite request and response groups
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } pae_axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pae_axi_rsp_t;
    typedef struct packed {
        logic [31:0] x;
        logic [31:0] y;
        logic [31:0] z;
        logic [31:0] w;
    } pae_vec_t;
endpackage
`default_nettype wire

// file: pae_top.sv
// Error recorder, primitive assembler and current attribute store
`default_nettype none
`include "pae_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// (R01) First error sets flag and stores code
// (R02) Stored code held while flag set
// (R03) Read returns code, clears flag
// (R04) Successive reads drain distinct pairs
// (R05) Reset clears flags, codes no-error
// (R06) Erroring command changes no state
// (R07) Only memory exhaustion may corrupt results
// (R08) Bad enumerated argument raises bad-enum
// (R09) Negative size raises bad-value
// (R10) Points: one point per vertex
// (R11) Strip lines keep previous vertex, first flag
// (R12) Each later vertex makes one segment
// (R13) Loop closes last back to first
// (R14) Separate lines pair; odd tail dropped
// (R15) Triangle strip waits for three vertices
// (R16) Two slots, one-bit pointer starting A
// (R17) Triangle ordered A, B, current
// (R18) Fan overwrites only slot B
// (R19) Separate triangles by threes, tail dropped
// (R20) Store holds four-component vectors per slot
// (R21) Short loads default y,z zero, w one
// (R22) Slot index out of range: bad-value
// (R23) Source loads matrix columns increasing slots
// (R24) Reset fills every slot with (0,0,0,1)
// (R25) Array widening defaults missing components
module pae_top #(
    parameter int SLOTS = 16,
    parameter int PAIRS = 2
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire pae_pkg::pae_axi_req_t I_AXI,
    output var pae_pkg::pae_axi_rsp_t O_AXI,
    input wire pae_pkg::pae_vtx_t I_VTX,
    output var pae_pkg::pae_prim_t O_PRIM,
    input wire logic [3:0] I_FETCH_SLOT,
    input wire logic [2:0] I_FETCH_SIZE,
    input wire logic [127:0] I_FETCH_RAW,
    output var pae_pkg::pae_vec_t O_FETCH_VEC
);
    import pae_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic bvalid;
        logic rvalid;
        logic [31:0] rdata;
        logic [PAIRS-1:0] err_flag;
        logic [PAIRS-1:0][31:0] err_code;
        pae_mode_t mode;
        pae_vec_t stage;
        pae_vec_t [SLOTS-1:0] attr;
        logic [31:0] va;
        logic [31:0] vb;
        logic [31:0] vfirst;
        logic repl_b;
        logic [1:0] count;
        logic seen_first;
        logic close_pend; // Loop segment owed
        pae_prim_t prim;
        pae_vec_t fvec;
    } pae_state_t;

    pae_state_t s; // Current state
    pae_state_t next_s; // Next state
    logic [PAIRS-1:0] raise; // Which pair an error is sent to
    logic [31:0] raise_code; // Code of error raised this cycle
    logic do_write; // Both write channels present
    logic [31:0] a; // Write data shorthand
    logic [4:0] slot_w; // Slot index of attribute load
    logic [2:0] cnt_w; // Value count of attribute load
    logic [31:0] vin; // Incoming vertex
    logic drain_hit; // Read found a set pair
    logic [31:0] drain_code; // Code returned by read
    logic [PAIRS-1:0] drain_mask; // Pair cleared by the read

    ////////////////////////////////////////////////////////////////////////////
    // Combinational next state
    always_comb begin
        next_s = s;
        raise = '0;
        raise_code = `PAE_ERR_NONE;
        a = s.w_data;
        slot_w = a[`PAE_ACMD_SLOT_LSB +: 5];
        cnt_w = a[`PAE_ACMD_COUNT_LSB +: 3];
        vin = I_VTX.data;
        drain_hit = 1'b0;
        drain_code = `PAE_ERR_NONE;
        drain_mask = '0;
        next_s.prim.valid = 1'b0;
        // Accept address and data independently, either order
        if (I_AXI.awvalid && !s.aw_got && !s.bvalid) begin
            next_s.aw_got = 1'b1;
            next_s.aw_addr = I_AXI.awaddr;
        end
        if (I_AXI.wvalid && !s.w_got && !s.bvalid) begin
            next_s.w_got = 1'b1;
            next_s.w_data = I_AXI.wdata;
        end
        do_write = s.aw_got && s.w_got && !s.bvalid;
        if (s.bvalid && I_AXI.bready) begin
            next_s.bvalid = 1'b0;
        end
        // Register writes; erroring commands update nothing
        if (do_write) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            case (s.aw_addr)
                `PAE_OFF_MODE: begin
                    if (a > 32'(`PAE_MODE_MAX)) begin
                        raise_code = `PAE_ERR_BAD_ENUM; // R08 R06
                    end else begin
                        next_s.mode = pae_mode_t'(a[2:0]);
                        next_s.count = 2'h0;
                        next_s.repl_b = 1'b0;
                        next_s.seen_first = 1'b0;
                    end
                end
                `PAE_OFF_ATTR_X: next_s.stage.x = a;
                `PAE_OFF_ATTR_Y: next_s.stage.y = a;
                `PAE_OFF_ATTR_Z: next_s.stage.z = a;
                `PAE_OFF_ATTR_W: next_s.stage.w = a;
                `PAE_OFF_ATTR_CMD: begin
                    if (a[`PAE_ACMD_SIGN_BIT] || cnt_w == 3'h0 || cnt_w > 3'h4) begin
                        raise_code = `PAE_ERR_BAD_VALUE; // R09
                    end else if (32'(slot_w) >= 32'(SLOTS) || a[30:13] != '0) begin
                        raise_code = `PAE_ERR_BAD_VALUE; // R22 R06
                    end else begin
                        // Unsupplied components take defaults
                        next_s.attr[slot_w[3:0]].x = s.stage.x; // R20
                        next_s.attr[slot_w[3:0]].y = (cnt_w >= 3'h2) ? s.stage.y
                            : `PAE_FLOAT_ZERO; // R21
                        next_s.attr[slot_w[3:0]].z = (cnt_w >= 3'h3) ? s.stage.z
                            : `PAE_FLOAT_ZERO; // R21
                        next_s.attr[slot_w[3:0]].w = (cnt_w == 3'h4) ? s.stage.w
                            : `PAE_FLOAT_ONE; // R21
                    end
                end
                `PAE_OFF_CMD_ERR: begin
                    // Errors found by outer command decoders
                    if (a[`PAE_CERR_MEM_BIT]) begin
                        raise_code = `PAE_ERR_MEM; // R07
                    end else if (a[`PAE_CERR_BAD_OP_BIT]) begin
                        raise_code = `PAE_ERR_BAD_OP;
                    end
                end
                default: begin
                end
            endcase
        end
        // Steer raised error to pair 0, or pair 1 for memory errors
        if (raise_code != `PAE_ERR_NONE) begin
            raise[(raise_code == `PAE_ERR_MEM && PAIRS > 1) ? 1 : 0] = 1'b1;
        end
        // Reads: error register drains one set pair per read
        if (s.rvalid && I_AXI.rready) begin
            next_s.rvalid = 1'b0;
        end
        if (I_AXI.arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            case (I_AXI.araddr)
                `PAE_OFF_ERR_READ: begin
                    for (int i = 0; i < PAIRS; i++) begin
                        if (s.err_flag[i] && !drain_hit) begin
                            drain_hit = 1'b1;
                            drain_code = s.err_code[i]; // R03 R04
                            drain_mask[i] = 1'b1;
                        end
                    end
                    next_s.rdata = drain_code; // R03
                end
                `PAE_OFF_MODE: next_s.rdata = {29'h0, s.mode};
                `PAE_OFF_STATUS: next_s.rdata = {24'h0, 3'h0, s.repl_b, s.count,
                    s.seen_first, |s.err_flag};
                default: next_s.rdata = 32'h0;
            endcase
        end
        // Flag update; a same-cycle clear wins, and an error raised into a set pair is dropped
        for (int i = 0; i < PAIRS; i++) begin
            if (drain_mask[i]) begin
                next_s.err_flag[i] = 1'b0; // R03
                next_s.err_code[i] = `PAE_ERR_NONE;
            end
            if (raise[i] && !s.err_flag[i]) begin
                next_s.err_flag[i] = 1'b1; // R01
                next_s.err_code[i] = raise_code; // R01 R02
            end
        end
        // Vertex stream assembly
        if (I_VTX.valid) begin
            next_s.prim.v2 = vin;
            case (s.mode)
                PAE_POINTS: begin
                    next_s.prim.valid = 1'b1; // R10
                    next_s.prim.kind = PAE_PRIM_POINT;
                    next_s.prim.v0 = vin;
                end
                PAE_LINE_STRIP, PAE_LINE_LOOP: begin
                    if (s.seen_first) begin
                        next_s.prim.valid = 1'b1; // R12
                        next_s.prim.kind = PAE_PRIM_LINE;
                        next_s.prim.v0 = s.va;
                        next_s.prim.v1 = vin;
                    end else begin
                        next_s.vfirst = vin; // R13
                    end
                    next_s.va = vin; // R11
                    next_s.seen_first = 1'b1;
                    // Closure owed to next cycle
                    if (I_VTX.last) begin
                        next_s.seen_first = 1'b0;
                        next_s.close_pend = s.mode == PAE_LINE_LOOP && s.seen_first; // R13
                    end
                end
                PAE_LINES: begin
                    if (s.seen_first) begin
                        next_s.prim.valid = 1'b1; // R14
                        next_s.prim.kind = PAE_PRIM_LINE;
                        next_s.prim.v0 = s.va;
                        next_s.prim.v1 = vin;
                    end
                    next_s.va = vin;
                    next_s.seen_first = !s.seen_first && !I_VTX.last; // R14
                end
                default: begin
                    // Triangle modes share slots A and B
                    if (s.count == 2'h2) begin
                        next_s.prim.valid = 1'b1; // R15 R17
                        next_s.prim.kind = PAE_PRIM_TRI;
                        next_s.prim.v0 = s.va;
                        next_s.prim.v1 = s.vb;
                    end else begin
                        next_s.count = s.count + 2'h1;
                    end
                    if (s.mode == PAE_TRIS) begin
                        // Groups of three restart independently
                        if (s.count == 2'h0) begin
                            next_s.va = vin; // R19
                        end else if (s.count == 2'h1) begin
                            next_s.vb = vin;
                        end else begin
                            next_s.count = 2'h0; // R19
                        end
                    end else if (s.mode == PAE_TRI_FAN && s.count != 2'h0) begin
                        next_s.vb = vin; // R18
                    end else if (s.repl_b) begin
                        next_s.vb = vin; // R16
                        next_s.repl_b = 1'b0;
                    end else begin
                        next_s.va = vin; // R16
                        next_s.repl_b = 1'b1;
                    end
                    if (s.mode == PAE_TRI_FAN && s.count == 2'h0) begin
                        next_s.repl_b = 1'b1;
                    end
                    if (I_VTX.last) begin
                        next_s.count = 2'h0; // R15 R19
                        next_s.repl_b = 1'b0;
                    end
                end
            endcase
        end
        // Owed loop segment goes out
        if (s.close_pend) begin
            next_s.close_pend = 1'b0;
            next_s.prim = {1'b1, PAE_PRIM_LINE, s.va, s.vfirst, vin}; // R13
        end
        // Widen fetched array data; disabled arrays read current values
        if (I_FETCH_SIZE == 3'h0) begin
            next_s.fvec = s.attr[I_FETCH_SLOT];
        end else begin
            next_s.fvec.x = I_FETCH_RAW[127:96];
            next_s.fvec.y = (I_FETCH_SIZE >= 3'h2) ? I_FETCH_RAW[95:64]
                : `PAE_FLOAT_ZERO; // R25
            next_s.fvec.z = (I_FETCH_SIZE >= 3'h3) ? I_FETCH_RAW[63:32]
                : `PAE_FLOAT_ZERO; // R25
            next_s.fvec.w = (I_FETCH_SIZE >= 3'h4) ? I_FETCH_RAW[31:0]
                : `PAE_FLOAT_ONE; // R25
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset loads constants only
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            s <= '0;
            for (int i = 0; i < SLOTS; i++) begin
                s.attr[i].w <= `PAE_FLOAT_ONE; // R24
            end
            for (int i = 0; i < PAIRS; i++) begin
                s.err_code[i] <= `PAE_ERR_NONE; // R05
            end
            s.fvec.w <= `PAE_FLOAT_ONE;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops only; the ready signals are gated from state bits
    always_comb begin
        O_AXI.awready = !s.aw_got && !s.bvalid;
        O_AXI.wready = !s.w_got && !s.bvalid;
        O_AXI.bvalid = s.bvalid;
        O_AXI.bresp = 2'h0;
        O_AXI.arready = !s.rvalid;
        O_AXI.rvalid = s.rvalid;
        O_AXI.rdata = s.rdata;
        O_AXI.rresp = 2'h0;
        O_PRIM = s.prim;
        O_FETCH_VEC = s.fvec;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    first_code_held_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        s.err_flag[0] && !drain_mask[0] |=> s.err_code[0] == $past(s.err_code[0])) // R02
        else $error("stored error code changed while flag set");
    error_captured_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        raise[0] && !s.err_flag[0] |=> s.err_flag[0] && s.err_code[0] != `PAE_ERR_NONE) // R01
        else $error("error not captured");
    read_clears_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        drain_mask[0] && !raise[0] |=> !s.err_flag[0] && s.rvalid) // R03
        else $error("read did not clear flag");
    empty_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_AXI.arvalid && !s.rvalid && I_AXI.araddr == `PAE_OFF_ERR_READ && s.err_flag == '0
        |=> s.rdata == `PAE_ERR_NONE) // R03
        else $error("read with no error returned a code");
    point_out_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_VTX.valid && s.mode == PAE_POINTS |=> O_PRIM.valid && O_PRIM.v0 == $past(vin)) // R10
        else $error("point not emitted");
    strip_wait_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_VTX.valid && s.mode == PAE_TRI_STRIP && s.count != 2'h2 |=> !O_PRIM.valid) // R15
        else $error("triangle before third vertex");
    tri_order_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_VTX.valid && s.mode == PAE_TRI_STRIP && s.count == 2'h2
        |=> O_PRIM.v0 == $past(s.va) && O_PRIM.v1 == $past(s.vb)) // R17
        else $error("triangle vertex order wrong");
    fan_keeps_a_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_VTX.valid && s.mode == PAE_TRI_FAN && s.count != 2'h0 |=> $stable(s.va)) // R18
        else $error("fan overwrote slot A");
endmodule
`default_nettype wire

// file: pae_host_model.sv
// Host command source model that feeds processed vertex handles of draw commands
`default_nettype none
module pae_host_model (
    input wire logic i_clk,
    output var pae_pkg::pae_vtx_t o_vtx
);
    timeunit 1ns;
    timeprecision 1ps;
    import pae_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Idle stream from time zero
    initial begin
        o_vtx = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One draw: n handles in order, one cycle each, gap idle cycles between them
    // Each idle cycle inverts the data before it, so with a gap of two the second idle cycle carries the handle again
    task automatic draw(input int n, input int gap);
        for (int i = 1; i <= n; i++) begin
            @(posedge i_clk);
            o_vtx <= {1'b1, (i == n), 32'h00000100 + 32'(i)};
            for (int g = 0; g < gap; g++) begin
                @(posedge i_clk);
                o_vtx <= {1'b0, 1'b0, ~o_vtx.data};
            end
        end
        @(posedge i_clk);
        o_vtx <= {1'b0, 1'b0, ~o_vtx.data};
    endtask
endmodule
`default_nettype wire

// file: pae_tb_top.sv
// Self-checking bench for the error recorder, assembler and attribute store
`default_nettype none
`include "pae_regs.svh"
module pae_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pae_pkg::*;
    // Staged attribute components, distinct so a swapped lane shows
    localparam logic [31:0] SX = 32'h40000000;
    localparam logic [31:0] SY = 32'h40400000;
    localparam logic [31:0] SZ = 32'h40800000;
    localparam logic [31:0] SW = 32'h40A00000;
    localparam logic [31:0] F0 = `PAE_FLOAT_ZERO;
    localparam logic [31:0] F1 = `PAE_FLOAT_ONE;
    typedef struct packed {logic [2:0] cnt; logic [3:0] slot; pae_vec_t exp;} pae_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1; // Held from time zero
    pae_axi_req_t axi = '0;
    pae_axi_rsp_t rsp;
    pae_vtx_t vtx;
    pae_prim_t prim;
    logic [3:0] f_slot = 4'h0;
    logic [2:0] f_size = 3'h0;
    logic [127:0] f_raw = '0;
    pae_vec_t f_vec;
    pae_prim_t got_q[$]; // Primitives seen at the output
    int fail_count = 0;
    int n_compared = 0;
    // Load count and slot beside the vector they must leave; slots rise row by row
    pae_row_t rows [4] = '{{3'h1, 4'h0, SX, F0, F0, F1}, {3'h2, 4'h1, SX, SY, F0, F1},
        {3'h3, 4'h2, SX, SY, SZ, F1}, {3'h4, 4'h3, SX, SY, SZ, SW}};

    ////////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    always #12.5 clk = ~clk;

    pae_top #(.SLOTS(8), .PAIRS(2)) u_pae_top (.I_CLK(clk), .I_RST(rst), .I_AXI(axi),
        .O_AXI(rsp), .I_VTX(vtx), .O_PRIM(prim), .I_FETCH_SLOT(f_slot),
        .I_FETCH_SIZE(f_size), .I_FETCH_RAW(f_raw), .O_FETCH_VEC(f_vec));
    pae_host_model u_pae_host_model (.i_clk(clk), .o_vtx(vtx));

    // Collect every primitive pulse; order is kept for comparison
    always @(posedge clk) begin
        if (prim.valid === 1'b1) begin
            got_q.push_back(prim);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic stop_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Bus master: both write channels offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int t;
        logic aw;
        logic w;
        t = 0;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        axi.awvalid <= 1'b1;
        axi.awaddr <= a;
        axi.wvalid <= 1'b1;
        axi.wdata <= d;
        axi.wstrb <= 4'hF;
        axi.bready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (!aw && rsp.awready === 1'b1) begin
                aw = 1'b1;
                axi.awvalid <= 1'b0;
            end
            if (!w && rsp.wready === 1'b1) begin
                w = 1'b1;
                axi.wvalid <= 1'b0;
            end
        end while (!(aw && w) && t < 200);
        while (rsp.bvalid !== 1'b1 && t < 200) begin
            @(posedge clk);
            t++;
        end
        axi.bready <= 1'b0;
        check("write wait", 32'(t >= 200), 32'h0);
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        axi.arvalid <= 1'b1;
        axi.araddr <= a;
        axi.rready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (rsp.arready !== 1'b1 && t < 200);
        axi.arvalid <= 1'b0;
        while (rsp.rvalid !== 1'b1 && t < 200) begin
            @(posedge clk);
            t++;
        end
        d = rsp.rdata;
        axi.rready <= 1'b0;
        check("read wait", 32'(t >= 200), 32'h0);
    endtask

    task automatic err_chk(input logic [31:0] e);
        logic [31:0] d;
        axi_read(`PAE_OFF_ERR_READ, d);
        check("error code", d, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Attribute load through the staged components and the command word
    task automatic load_attr(input logic [3:0] s, input logic [2:0] c, input logic neg);
        axi_write(`PAE_OFF_ATTR_X, SX);
        axi_write(`PAE_OFF_ATTR_Y, SY);
        axi_write(`PAE_OFF_ATTR_Z, SZ);
        axi_write(`PAE_OFF_ATTR_W, SW);
        axi_write(`PAE_OFF_ATTR_CMD, {neg, 20'h0, c, 3'h0, 1'b0, s});
    endtask

    // Fetch result is registered, so it is read two edges after the inputs change
    task automatic fetch_chk(input logic [3:0] s, input logic [2:0] z, input pae_vec_t e);
        @(posedge clk);
        f_slot <= s;
        f_size <= z;
        f_raw <= {SX, SY, SZ, SW};
        repeat (2) @(posedge clk);
        check("vector x", f_vec.x, e.x);
        check("vector y", f_vec.y, e.y);
        check("vector z", f_vec.z, e.z);
        check("vector w", f_vec.w, e.w);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // One draw in mode m with its expected primitives worked out alongside
    task automatic run_draw(input pae_mode_t m, input int n, input bit wr);
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] p;
        logic [31:0] f;
        logic [31:0] v;
        logic ptr;
        pae_prim_t e[$];
        a = '0;
        b = '0;
        p = '0;
        f = '0;
        ptr = 1'b0;
        if (wr) axi_write(`PAE_OFF_MODE, {29'h0, m});
        got_q.delete();
        u_pae_host_model.draw(n, m[0] ? 0 : 2);
        repeat (8) @(posedge clk);
        for (int i = 1; i <= n; i++) begin
            v = 32'h00000100 + 32'(i);
            case (m)
                PAE_POINTS: e.push_back({1'b1, PAE_PRIM_POINT, v, 64'h0});
                PAE_LINE_STRIP, PAE_LINE_LOOP: begin
                    if (i > 1) e.push_back({1'b1, PAE_PRIM_LINE, p, v, 32'h0});
                    if (i == 1) f = v;
                end
                PAE_LINES: if (i % 2 == 0) e.push_back({1'b1, PAE_PRIM_LINE, p, v, 32'h0});
                default: begin
                    if ((m != PAE_TRIS && i >= 3) || (m == PAE_TRIS && i % 3 == 0))
                        e.push_back({1'b1, PAE_PRIM_TRI, a, b, v});
                    if (m == PAE_TRIS) begin
                        if (i % 3 == 1) a = v;
                        else b = v;
                    end else if (m == PAE_TRI_FAN && i > 1) b = v;
                    else if (ptr) b = v;
                    else a = v;
                    ptr = ~ptr;
                end
            endcase
            p = v;
        end
        if (m == PAE_LINE_LOOP && n > 1) e.push_back({1'b1, PAE_PRIM_LINE, p, f, 32'h0});
        check("prim count", 32'(got_q.size()), 32'(e.size()));
        for (int k = 0; k < e.size() && k < got_q.size(); k++) begin
            check("prim kind", {30'h0, got_q[k].kind}, {30'h0, e[k].kind});
            check("prim v0", got_q[k].v0, e[k].v0);
            if (e[k].kind != PAE_PRIM_POINT) check("prim v1", got_q[k].v1, e[k].v1);
            if (e[k].kind == PAE_PRIM_TRI) check("prim v2", got_q[k].v2, e[k].v2);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog far beyond the several hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end

    // Main sequence: reset, table rows, every mode, then the awkward cases
    initial begin
        logic [31:0] r1;
        logic [31:0] r2;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        err_chk(`PAE_ERR_NONE);
        fetch_chk(4'h0, 3'h0, {F0, F0, F0, F1});
        fetch_chk(4'h7, 3'h0, {F0, F0, F0, F1});
        axi_write(8'h40, 32'h00001234);
        axi_read(8'h40, r1);
        check("unmapped read", r1, 32'h0);
        foreach (rows[i]) begin
            load_attr(rows[i].slot, rows[i].cnt, 1'b0);
            fetch_chk(rows[i].slot, 3'h0, rows[i].exp);
            fetch_chk(4'h0, rows[i].cnt, rows[i].exp);
        end
        for (int m = 0; m < 7; m++) run_draw(pae_mode_t'(m), 5, 1'b1);
        run_draw(PAE_TRI_STRIP, 2, 1'b1);
        // Bad mode is refused; the strip mode must survive it
        axi_write(`PAE_OFF_MODE, 32'h00000007);
        run_draw(PAE_TRI_STRIP, 3, 1'b0);
        // Out-of-range slot while the first error is still held
        load_attr(4'h8, 3'h4, 1'b0);
        err_chk(`PAE_ERR_BAD_ENUM);
        err_chk(`PAE_ERR_NONE);
        fetch_chk(4'h0, 3'h0, rows[0].exp);
        load_attr(4'h1, 3'h1, 1'b1);
        err_chk(`PAE_ERR_BAD_VALUE);
        fetch_chk(4'h1, 3'h0, rows[1].exp);
        // Two pairs set in turn drain, pair 0 first; the check accepts either order
        axi_write(`PAE_OFF_CMD_ERR, 32'h00000002);
        axi_write(`PAE_OFF_CMD_ERR, 32'h00000001);
        axi_read(`PAE_OFF_ERR_READ, r1);
        axi_read(`PAE_OFF_ERR_READ, r2);
        check("drain pair", 32'((r1 === `PAE_ERR_BAD_OP && r2 === `PAE_ERR_MEM) ||
            (r1 === `PAE_ERR_MEM && r2 === `PAE_ERR_BAD_OP)), 32'h1);
        err_chk(`PAE_ERR_NONE);
        // Reset in mid-run with an error pending and a slot loaded
        axi_write(`PAE_OFF_CMD_ERR, 32'h00000001);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        err_chk(`PAE_ERR_NONE);
        fetch_chk(4'h1, 3'h0, {F0, F0, F0, F1});
        stop_test();
    end
endmodule
`default_nettype wire
